//--- macrocell_pkg.sv
// constants and mode encodings for the eight output macrocells
// assumes a single 20 MHz clock domain and a product-term array outside
//
// Contract
// - three global modes, registered, complex, simple, shared by all eight cells
// - sync mode bit and global arch bit pick the mode for every cell
// - configuration is two global bits plus twenty-four per-cell bits
// - polarity bit clear gives active low output, set gives active high
// - simple mode: direction bit clear is combinatorial output, set is input
// - simple mode when sync bit is one and arch bit is zero
// - registered mode fixes clock and enable pins, not usable as inputs
// - registered cells share one clock and one output-enable pin
// - registered mode: each cell registered output or combinatorial I/O
// - registered output sums eight terms; I/O sums seven, eighth enables
// - complex mode: clock and enable pins become inputs via outer feedback
// - complex mode: six cells may input; the two outer cells output only
// - complex mode: seven terms sum, one term drives output enable
// - simple mode outputs always driven, no enable control
// - simple mode outer cells feed back via neighbours; two centre cells fixed outputs
// - simple mode output uses at most eight product terms
// - registers capture on rising edge of the shared clock
// - registers clear at reset and accept a test preload
`default_nettype none
package macrocell_pkg;
   localparam int NUM_CELLS = 8;
   localparam int TERMS_PER_CELL = 8;
   localparam int NUM_TERMS = NUM_CELLS * TERMS_PER_CELL;
   localparam int OUTER_LO = 0;
   localparam int OUTER_HI = 7;
   localparam int CENTRE_LO = 3;
   localparam int CENTRE_HI = 4;
   localparam int OE_TERM = 0;
   localparam logic [7:0] REG_RESET = 8'h00;
   typedef enum logic [1:0] {
      MODE_SIMPLE = 2'b00,
      MODE_COMPLEX = 2'b01,
      MODE_REGISTERED = 2'b10
   } mode_e;
endpackage : macrocell_pkg
`default_nettype wire

//--- output_macrocell.sv
// eight configurable output macrocells behind a product-term array
// assumes product terms arrive from same-clock logic; pins pass three flops
`default_nettype none
module output_macrocell
   import macrocell_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic syncModeBit,
   input wire logic globalArchSelect,
   input wire logic [7:0] polarityBit,
   input wire logic [7:0] ioDirectionBit,
   input wire logic [7:0] registeredCell,
   input wire logic [63:0] productTerm,
   input wire logic clockPin,
   input wire logic enablePin,
   input wire logic [7:0] padIn,
   input wire logic preloadEn,
   input wire logic [7:0] preloadData,
   output logic [7:0] padOut,
   output logic [7:0] padOe,
   output logic [7:0] feedback,
   output logic clockPinIn,
   output logic enablePinIn,
   output logic [1:0] mode
);
   // ************************************************
   // pin synchronisers and mode decode
   // ************************************************
   logic [2:0] clkSync;
   logic [2:0] oeSync;
   logic [7:0] padS1, padS2, padS3;
   logic clkLevel, oeLevel;
   logic [7:0] padLevel;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clkSync <= 3'h0;
         oeSync <= 3'h7;
         padS1 <= 8'h00;
         padS2 <= 8'h00;
         padS3 <= 8'h00;
      end else begin
         clkSync <= {clkSync[1:0], clockPin};
         oeSync <= {oeSync[1:0], enablePin};
         padS1 <= padIn;
         padS2 <= padS1;
         padS3 <= padS2;
      end
   end

   // a change counts once the second and third stages agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clkLevel <= 1'b0;
         oeLevel <= 1'b1;
         padLevel <= 8'h00;
      end else begin
         if (clkSync[1] == clkSync[2]) clkLevel <= clkSync[2];
         if (oeSync[1] == oeSync[2]) oeLevel <= oeSync[2];
         padLevel <= (padS2 & padS3) | (padLevel & (padS2 ^ padS3));
      end
   end

   // sync bit set and arch bit clear is simple; arch bit set is complex
   wire mode_e curMode = syncModeBit ? (globalArchSelect ? MODE_COMPLEX : MODE_SIMPLE)
                                     : MODE_REGISTERED;
   wire isReg = (curMode == MODE_REGISTERED);
   wire isCplx = (curMode == MODE_COMPLEX);
   wire isSimple = (curMode == MODE_SIMPLE);
   wire clkRise = clkLevel & ~clkSync[2] ? 1'b0 : (~clkLevel & clkSync[2] & clkSync[1]);
   // masks used by the checks below
   localparam logic [NUM_CELLS-1:0] CENTRE_MASK = (8'h01 << CENTRE_LO) | (8'h01 << CENTRE_HI);
   localparam logic [NUM_TERMS-1:0] OE_TERM_MASK = {NUM_CELLS{8'h01 << OE_TERM}};

   // ************************************************
   // per-cell sums and output stage
   // ************************************************
   function automatic logic termOr(input logic [7:0] t, input logic useEight);
      termOr = useEight ? |t : |t[7:1];
   endfunction : termOr

   logic [7:0] cellReg;
   logic [7:0] next_cellReg;
   logic [7:0] combSum, fullSum, drvVal, drvOe, fbVal;
   logic [7:0] oeTermBits;

   always_comb begin
      for (int i = 0; i < NUM_CELLS; i++) begin
         fullSum[i] = termOr(productTerm[i*TERMS_PER_CELL +: TERMS_PER_CELL], 1'b1);
         combSum[i] = termOr(productTerm[i*TERMS_PER_CELL +: TERMS_PER_CELL], 1'b0);
         oeTermBits[i] = productTerm[i*TERMS_PER_CELL + OE_TERM];
         next_cellReg[i] = fullSum[i] ^ ~polarityBit[i];
         if (isReg && registeredCell[i]) begin
            drvVal[i] = cellReg[i];
            drvOe[i] = ~oeLevel;
            fbVal[i] = cellReg[i];
         end else if (isSimple) begin
            drvVal[i] = fullSum[i] ^ ~polarityBit[i];
            drvOe[i] = (i == CENTRE_LO || i == CENTRE_HI) ? 1'b1 : ~ioDirectionBit[i];
            fbVal[i] = padLevel[i];
         end else begin
            drvVal[i] = combSum[i] ^ ~polarityBit[i];
            drvOe[i] = oeTermBits[i];
            fbVal[i] = padLevel[i];
         end
      end
      // outer cells lose feedback in complex mode: pins arrive there instead
      if (isCplx) begin
         fbVal[OUTER_HI] = clkLevel;
         fbVal[OUTER_LO] = oeLevel;
      end
      // simple mode: outer cells feed back the neighbour's pad, centre cells none
      if (isSimple) begin
         fbVal[CENTRE_LO] = 1'b0;
         fbVal[CENTRE_HI] = 1'b0;
         fbVal[OUTER_LO] = padLevel[OUTER_LO + 1];
         fbVal[OUTER_HI] = padLevel[OUTER_HI - 1];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) cellReg <= REG_RESET;
      else if (preloadEn) cellReg <= preloadData;
      else if (isReg && clkRise) cellReg <= next_cellReg;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         padOut <= 8'h00;
         padOe <= 8'h00;
         feedback <= 8'h00;
         clockPinIn <= 1'b0;
         enablePinIn <= 1'b0;
         // wakes as registered: registered cells stay floated until the enable pin settles
         mode <= MODE_REGISTERED;
      end else begin
         padOut <= drvVal;
         padOe <= drvOe;
         feedback <= fbVal;
         clockPinIn <= isReg ? 1'b0 : clkLevel;
         enablePinIn <= isReg ? 1'b0 : oeLevel;
         mode <= curMode;
      end
   end

   // ************************************************
   // checks
   // ************************************************
   a_simple_centre_driven: assert property (@(posedge clk) disable iff (!nrst)
      (mode == MODE_SIMPLE) |-> (padOe[CENTRE_LO] && padOe[CENTRE_HI]))
      else $error("centre cell not driven in simple mode");
   a_reg_pins_fixed: assert property (@(posedge clk) disable iff (!nrst)
      (mode == MODE_REGISTERED) |-> (!clockPinIn && !enablePinIn))
      else $error("clock or enable pin leaked as input");
   a_reg_holds_no_edge: assert property (@(posedge clk) disable iff (!nrst)
      (!clkRise && !preloadEn) |=> $stable(cellReg))
      else $error("register changed without clock edge");
   a_preload_loads: assert property (@(posedge clk) disable iff (!nrst)
      preloadEn |=> (cellReg == $past(preloadData)))
      else $error("preload not taken");
   a_simple_dir: assert property (@(posedge clk) disable iff (!nrst)
      (isSimple && ioDirectionBit[0]) |=> !padOe[0])
      else $error("input cell driven in simple mode");
   a_mode_decode: assert property (@(posedge clk) disable iff (!nrst)
      (syncModeBit && !globalArchSelect) |=> (mode == MODE_SIMPLE))
      else $error("simple mode not decoded");
   a_reg_oe_shared: assert property (@(posedge clk) disable iff (!nrst)
      (isReg && registeredCell[1] && oeLevel) |=> !padOe[1])
      else $error("registered output driven while enable high");
   a_cplx_outer_fb: assert property (@(posedge clk) disable iff (!nrst)
      isCplx |=> (feedback[OUTER_HI] == $past(clkLevel)))
      else $error("outer feedback not carrying clock pin");

   // ************************************************
   // registered mode checks
   // ************************************************
   a_reg_oe_enable: assert property (@(posedge clk) disable iff (!nrst)
      (isReg && !oeLevel)
      |=> ((padOe & $past(registeredCell)) == $past(registeredCell)))
      else $error("registered output not enabled");
   a_reg_oe_disable: assert property (@(posedge clk) disable iff (!nrst)
      (isReg && oeLevel)
      |=> ((padOe & $past(registeredCell)) == 8'h00))
      else $error("registered output driven while floated");
   a_reg_out_value: assert property (@(posedge clk) disable iff (!nrst)
      isReg
      |=> ((padOut & $past(registeredCell)) == ($past(cellReg) & $past(registeredCell))))
      else $error("registered cell not showing its register");
   a_reg_fb_value: assert property (@(posedge clk) disable iff (!nrst)
      isReg
      |=> ((feedback & $past(registeredCell)) == ($past(cellReg) & $past(registeredCell))))
      else $error("registered cell feedback wrong");
   a_reg_io_fb: assert property (@(posedge clk) disable iff (!nrst)
      isReg
      |=> ((feedback & ~$past(registeredCell)) == ($past(padLevel) & ~$past(registeredCell))))
      else $error("io cell feedback not from pad");
   a_reg_io_oe: assert property (@(posedge clk) disable iff (!nrst)
      isReg
      |=> ((padOe & ~$past(registeredCell)) == ($past(oeTermBits) & ~$past(registeredCell))))
      else $error("io cell enable not from its term");
   a_reg_io_seven: assert property (@(posedge clk) disable iff (!nrst)
      (isReg && ((productTerm & ~OE_TERM_MASK) == '0))
      |=> ((padOut & ~$past(registeredCell)) == (~$past(polarityBit) & ~$past(registeredCell))))
      else $error("enable term leaked into io sum");
   a_reg_load_edge: assert property (@(posedge clk) disable iff (!nrst)
      (isReg && clkRise && !preloadEn)
      |=> (cellReg == $past(next_cellReg)))
      else $error("register missed clock edge");
   a_no_load_other: assert property (@(posedge clk) disable iff (!nrst)
      (!isReg && !preloadEn)
      |=> $stable(cellReg))
      else $error("register loaded outside registered mode");
   a_preload_first: assert property (@(posedge clk) disable iff (!nrst)
      (preloadEn && isReg && clkRise)
      |=> (cellReg == $past(preloadData)))
      else $error("preload lost to clock edge");
   a_rise_single: assert property (@(posedge clk) disable iff (!nrst)
      clkRise
      |=> !clkRise)
      else $error("clock edge seen twice");
   a_rise_needs_pin: assert property (@(posedge clk) disable iff (!nrst)
      clkRise
      |-> (clkSync[1] && clkSync[2] && !clkLevel))
      else $error("clock edge without settled pin");

   // ************************************************
   // complex and simple mode checks
   // ************************************************
   a_cplx_oe_term: assert property (@(posedge clk) disable iff (!nrst)
      isCplx
      |=> (padOe == $past(oeTermBits)))
      else $error("complex enable not from its term");
   a_cplx_seven: assert property (@(posedge clk) disable iff (!nrst)
      (isCplx && ((productTerm & ~OE_TERM_MASK) == '0))
      |=> (padOut == ~$past(polarityBit)))
      else $error("enable term leaked into complex sum");
   a_cplx_outer_lo: assert property (@(posedge clk) disable iff (!nrst)
      isCplx
      |=> (feedback[OUTER_LO] == $past(oeLevel)))
      else $error("outer feedback not carrying enable pin");
   a_cplx_inner_fb: assert property (@(posedge clk) disable iff (!nrst)
      isCplx
      |=> (feedback[OUTER_HI-1:OUTER_LO+1] == $past(padLevel[OUTER_HI-1:OUTER_LO+1])))
      else $error("inner cell feedback not from pad");
   a_cplx_pins_in: assert property (@(posedge clk) disable iff (!nrst)
      isCplx
      |=> (clockPinIn == $past(clkLevel) && enablePinIn == $past(oeLevel)))
      else $error("pins not offered as inputs");
   a_simple_pins_in: assert property (@(posedge clk) disable iff (!nrst)
      isSimple
      |=> (clockPinIn == $past(clkLevel) && enablePinIn == $past(oeLevel)))
      else $error("pins not offered as inputs");
   a_simple_oe_dir: assert property (@(posedge clk) disable iff (!nrst)
      isSimple
      |=> (padOe == ($past(~ioDirectionBit) | CENTRE_MASK)))
      else $error("simple enable not from direction bit");
   a_simple_zero_sum: assert property (@(posedge clk) disable iff (!nrst)
      (isSimple && (productTerm == '0))
      |=> (padOut == ~$past(polarityBit)))
      else $error("polarity wrong for false sum");
   a_simple_full_sum: assert property (@(posedge clk) disable iff (!nrst)
      (isSimple && (&productTerm))
      |=> (padOut == $past(polarityBit)))
      else $error("polarity wrong for true sum");
   a_simple_swap_lo: assert property (@(posedge clk) disable iff (!nrst)
      isSimple
      |=> (feedback[OUTER_LO] == $past(padLevel[OUTER_LO+1])))
      else $error("low outer feedback not from neighbour");
   a_simple_swap_hi: assert property (@(posedge clk) disable iff (!nrst)
      isSimple
      |=> (feedback[OUTER_HI] == $past(padLevel[OUTER_HI-1])))
      else $error("high outer feedback not from neighbour");
   a_simple_centre_fb: assert property (@(posedge clk) disable iff (!nrst)
      isSimple
      |=> (!feedback[CENTRE_LO] && !feedback[CENTRE_HI]))
      else $error("centre cell has feedback");

   // ************************************************
   // decode and synchroniser checks
   // ************************************************
   a_mode_reg: assert property (@(posedge clk) disable iff (!nrst)
      !syncModeBit
      |=> (mode == MODE_REGISTERED))
      else $error("registered mode not decoded");
   a_mode_cplx: assert property (@(posedge clk) disable iff (!nrst)
      (syncModeBit && globalArchSelect)
      |=> (mode == MODE_COMPLEX))
      else $error("complex mode not decoded");
   a_mode_legal: assert property (@(posedge clk) disable iff (!nrst)
      1'b1
      |-> (mode inside {MODE_SIMPLE, MODE_COMPLEX, MODE_REGISTERED}))
      else $error("illegal mode reported");
   a_mode_follows: assert property (@(posedge clk) disable iff (!nrst)
      $changed(curMode)
      |=> (mode == $past(curMode)))
      else $error("mode output lags decode");
   a_clk_agree: assert property (@(posedge clk) disable iff (!nrst)
      (clkSync[1] == clkSync[2])
      |=> (clkLevel == $past(clkSync[2])))
      else $error("clock level ignores agreed stages");
   a_oe_agree: assert property (@(posedge clk) disable iff (!nrst)
      (oeSync[1] == oeSync[2])
      |=> (oeLevel == $past(oeSync[2])))
      else $error("enable level ignores agreed stages");
   a_pad_agree: assert property (@(posedge clk) disable iff (!nrst)
      (padS2 == padS3)
      |=> (padLevel == $past(padS3)))
      else $error("pad level ignores agreed stages");
   c_reg_mode: cover property (@(posedge clk) disable iff (!nrst) isReg && clkRise);
   c_cplx_mode: cover property (@(posedge clk) disable iff (!nrst) isCplx);
   c_simple_mode: cover property (@(posedge clk) disable iff (!nrst) isSimple);
   c_preload: cover property (@(posedge clk) disable iff (!nrst) preloadEn && isReg);
   c_simple_input: cover property (@(posedge clk) disable iff (!nrst) isSimple && |ioDirectionBit);
endmodule : output_macrocell
`default_nettype wire

//--- board_pins.sv
// board-side driver for the clock, enable and pad pins of the macrocells
// assumes the bench steers it between rising clock edges
`default_nettype none
module board_pins (
   input wire logic clk,
   input wire logic pulse,
   input wire logic outEnable,
   output logic clockPin,
   output logic enablePin,
   output logic [7:0] padIn
);
   timeunit 1ns;
   timeprecision 1ns;
   // pin clock stands low outside pulses, held long for the synchroniser
   always @(negedge clk) clockPin <= pulse;
   assign enablePin = !outEnable;
   assign padIn = 8'h3c;
endmodule : board_pins
`default_nettype wire

//--- output_macrocell_tb.sv
// self-checking bench for the eight output macrocells
// assumes the package and a board_pins model for the async pins
`default_nettype none
module output_macrocell_tb import macrocell_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, nrst = 0, syncModeBit = 0, globalArchSelect = 0, preloadEn = 0;
   logic pulse = 0, outEnable = 1, clockPin, enablePin, clockPinIn, enablePinIn;
   logic [7:0] polarityBit = 8'hff, ioDirectionBit = 8'h00, registeredCell = 8'hff;
   logic [7:0] preloadData = 8'h00, padIn, padOut, padOe, feedback;
   logic [63:0] productTerm = 64'h0;
   logic [1:0] mode;
   int n_errors = 0, n_compared = 0, cycles = 0;
   output_macrocell i_output_macrocell (.clk(clk), .nrst(nrst), .syncModeBit(syncModeBit),
      .globalArchSelect(globalArchSelect), .polarityBit(polarityBit),
      .ioDirectionBit(ioDirectionBit), .registeredCell(registeredCell),
      .productTerm(productTerm), .clockPin(clockPin), .enablePin(enablePin), .padIn(padIn),
      .preloadEn(preloadEn), .preloadData(preloadData), .padOut(padOut), .padOe(padOe),
      .feedback(feedback), .clockPinIn(clockPinIn), .enablePinIn(enablePinIn), .mode(mode));
   board_pins i_board_pins (.clk(clk), .pulse(pulse), .outEnable(outEnable),
      .clockPin(clockPin), .enablePin(enablePin), .padIn(padIn));
   // ********
   // helpers
   // ********
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      n_compared++;
      if (seen !== want) begin
         n_errors++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_n
   task automatic set_mode(input logic s, input logic a);
      syncModeBit = s;
      globalArchSelect = a;
      wait_n(6);
   endtask : set_mode
   task automatic print_verdict;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict
   // ********
   // scenarios
   // ********
   task automatic test_modes;
      set_mode(1'b0, 1'b1);
      check({6'h00, mode}, {6'h00, MODE_REGISTERED});
      check({6'h00, clockPinIn, enablePinIn}, 8'h00);
      set_mode(1'b1, 1'b1);
      check({6'h00, mode}, {6'h00, MODE_COMPLEX});
      set_mode(1'b1, 1'b0);
      check({6'h00, mode}, {6'h00, MODE_SIMPLE});
   endtask : test_modes
   task automatic test_registered;
      set_mode(1'b0, 1'b0);
      preloadEn = 1;
      preloadData = 8'ha5;
      wait_n(1);
      preloadEn = 0;
      wait_n(3);
      check(padOut, 8'ha5);
      check(padOe, 8'hff);
      outEnable = 0;
      wait_n(6);
      check(padOe, 8'h00);
      outEnable = 1;
      productTerm = '1;
      pulse = 1;
      wait_n(6);
      pulse = 0;
      wait_n(6);
      check(padOut, 8'hff);
      // combinatorial cells see only their enable term
      productTerm = 64'h0101010101010101;
      registeredCell = 8'h0f;
      wait_n(3);
      check(padOut, 8'h0f);
      check(padOe, 8'hff);
   endtask : test_registered
   task automatic test_simple;
      set_mode(1'b1, 1'b0);
      productTerm = '0;
      polarityBit = 8'h0f;
      ioDirectionBit = 8'hff;
      wait_n(3);
      check(padOe, 8'h18);
      check(padOut & padOe, 8'h10);
      ioDirectionBit = 8'h00;
      wait_n(3);
      check(padOe, 8'hff);
      check(feedback, 8'h24);
      productTerm = '1;
      wait_n(3);
      check(padOut, 8'h0f);
   endtask : test_simple
   task automatic test_complex;
      set_mode(1'b1, 1'b1);
      productTerm = 64'h0000000100000001;
      wait_n(3);
      check(padOe, 8'h11);
      check(padOut & padOe, 8'h10);
      pulse = 1;
      outEnable = 0;
      wait_n(6);
      check({6'h00, clockPinIn, enablePinIn}, 8'h03);
      check(feedback, 8'hbd);
      pulse = 0;
   endtask : test_complex
   initial begin
      forever #25 clk = ~clk;
   end
   // hang guard well beyond the eighty-odd cycles the scenarios need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         print_verdict();
      end
   end
   initial begin
      wait_n(2);
      nrst = 1;
      test_modes();
      test_registered();
      test_simple();
      test_complex();
      print_verdict();
   end
endmodule : output_macrocell_tb
`default_nettype wire
